// ### rio_core.sv
// What this block does
// - Up to ten field inputs; the first six each mapped to one input function or none, the other four to none.
// - Per-input polarity selects whether high or low terminal level is active.
// - Input goes active after level stays active for its ON delay.
// - Input goes inactive after level stays inactive for its OFF delay.
// - With event display enabled, each qualified input change sets an event.
// - Per-relay idle polarity sets contact state while relay is inactive.
// - A relay, except in the ready role, stays active for its pulse width after its trigger appears.
// - On the trip relay a present trip holds it past the pulse width.
// - A relay turns on only after its ON delay following the trigger.
// - Ready role only on output six; there active-off polarity is ignored.
// - Breaker open commands trigger the trip relay like protection trips, but do not hold it past the pulse width.
// - Relays one to three triggered from five signal groups by per-signal selection, relay four from the first group only.
// - General relays apply latched, non-latched or pulse mode per signal.
// - Trip relay applies the same per-signal latched, non-latched or pulse modes.
// - Close and ready relays trigger only on their own function; mapped latched or non-latched signals still hold the close relay on.
// - LEDs one to three use the same groups, LED four the first only, per-signal latched, non-latched or blinking.
// - One LED can mix different modes for different signals.
// - Reset and clear commands; lockout, events, records need level one.
// - Device auto-locks after an idle time of 1 to 60 minutes.
// - Level one permits all commands but no settings; level two also settings.
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rio_defines.svh"

module rio_core #(
    parameter int NIN        = 10,
    parameter int NOUT       = 6,
    parameter int NLED       = 8,
    parameter int NSIG       = 5,
    parameter int MS_CYCLES  = `RIO_MS_CYCLES,
    parameter int MIN_MS     = `RIO_MIN_MS
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             clk_en,
    // Wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // Field side
    input  wire logic [NIN-1:0]   field_input,
    input  wire logic [NSIG-1:0]  int_sig,
    input  wire logic             trip_sig,
    input  wire logic             open_cmd,
    input  wire logic             close_cmd,
    input  wire logic             ready_sig,
    output logic      [NOUT-1:0]  relay_out,
    output logic      [NLED-1:0]  led_out,
    output logic      [NIN-1:0]   func_active,
    output logic                  locked
);
    localparam int W = 16;

    logic [NIN-1:0]     s1_q, s2_q;
    logic [NIN-1:0]     pol_q, evt_en_q, qual_q, evt_q;
    logic [W-1:0]       on_ms_q, off_ms_q;
    logic [NOUT-1:0]    opol_q;
    logic [W-1:0]       pulse_ms_q, oon_ms_q;
    logic [2*NOUT-1:0]  role_q;
    logic [NIN*5-1:0]   fsel_q;
    logic [NOUT*NSIG*2-1:0] rmap_q;
    logic [NLED*NSIG*2-1:0] lmap_q;
    logic [NOUT*NSIG-1:0]   rlat_q;
    logic [NLED*NSIG-1:0]   llat_q;
    logic [1:0]         lvl_q;
    logic [7:0]         lock_min_q;
    logic [31:0]        idle_q;
    logic [31:0]        tick_q;
    logic               ms_tick;
    logic [8:0]         blink_q;
    logic               blink_ph_q;
    logic [7:0]         cmd_pulse;
    logic [7:0]         alarm_clr_cnt_q;
    logic               wr, rd_hit;
    logic [NOUT-1:0]    rly_q;
    logic [NLED-1:0]    led_q;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

    // Input synchronisers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else if (clk_en)
        begin
            s1_q <= field_input;
            s2_q <= s1_q;
        end
    end

    // Millisecond tick
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            tick_q <= '0;
        else if (clk_en)
            tick_q <= (tick_q == 32'(MS_CYCLES - 1)) ? '0 : tick_q + 32'd1;
    end
    assign ms_tick = (tick_q == 32'(MS_CYCLES - 1));

    // Blink phase for blinking LEDs
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            blink_q    <= '0;
            blink_ph_q <= 1'b0;
        end
        else if (clk_en && ms_tick)
        begin
            if (blink_q == 9'(`RIO_BLINK_MS - 1))
            begin
                blink_q    <= '0;
                blink_ph_q <= !blink_ph_q;
            end
            else
                blink_q <= blink_q + 9'd1;
        end
    end

    // Command decode with access level gating
    always_comb
    begin
        cmd_pulse = '0;
        if (wr && wb_adr_i == `RIO_OFS_CMD)
        begin
            cmd_pulse = wb_dat_i[7:0];
            if (lvl_q == rio_pkg::RIO_LVL_LOCKED)
            begin
                cmd_pulse[`RIO_CMD_RST_LOCK] = 1'b0;
                cmd_pulse[`RIO_CMD_CLR_EVT]  = 1'b0;
                cmd_pulse[`RIO_CMD_CLR_REC]  = 1'b0;
            end
        end
    end

    // Configuration writes; settings need level two, lockout, event and record clears level one
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pol_q <= '1; evt_en_q <= '0; fsel_q <= '0;
            on_ms_q <= 16'h0014; off_ms_q <= 16'h0014;
            opol_q <= '0; pulse_ms_q <= 16'h00C8; oon_ms_q <= '0;
            role_q <= '0; rmap_q <= '0; lmap_q <= '0;
            lock_min_q <= `RIO_LOCK_MIN_DEF;
        end
        else if (clk_en && wr && lvl_q == rio_pkg::RIO_LVL_TWO)
        begin
            case (wb_adr_i)
                `RIO_OFS_IN_CFG0:
                begin
                    pol_q    <= wb_dat_i[NIN-1:0];
                    evt_en_q <= wb_dat_i[16+NIN-1:16];
                end
                `RIO_OFS_TIMING:
                begin
                    on_ms_q  <= wb_dat_i[15:0];
                    off_ms_q <= wb_dat_i[31:16];
                end
                `RIO_OFS_OUT_CFG:
                begin
                    opol_q     <= wb_dat_i[NOUT-1:0];
                    pulse_ms_q <= wb_dat_i[31:16];
                    oon_ms_q   <= {8'h00, wb_dat_i[15:8]};
                end
                `RIO_OFS_ROLE:
                begin
                    role_q     <= wb_dat_i[2*NOUT-1:0];
                    lock_min_q <= (wb_dat_i[23:16] < 8'd1) ? 8'd1 :
                                  (wb_dat_i[23:16] > 8'd60) ? 8'd60 : wb_dat_i[23:16];
                    // Ready role only allowed on output six
                    for (int i = 0; i < NOUT - 1; i++)
                        if (wb_dat_i[2*i +: 2] == rio_pkg::RIO_ROLE_READY)
                            role_q[2*i +: 2] <= rio_pkg::RIO_ROLE_GEN;
                end
                `RIO_OFS_INSEL: fsel_q <= wb_dat_i[NIN*3-1:0] == '0 ? '0 :
                                          {{(NIN*5-30){1'b0}}, wb_dat_i[29:0]};
                `RIO_OFS_RLY_MAP: rmap_q <= {{(NOUT*NSIG*2-32){1'b0}}, wb_dat_i};
                `RIO_OFS_LED_MAP: lmap_q <= {{(NLED*NSIG*2-32){1'b0}}, wb_dat_i};
                default: ;
            endcase
        end
    end

    // Input qualification per channel
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++)
        begin : g_in
            logic [W-1:0] cnt_q;
            logic         act;
            assign act = (s2_q[gi] == pol_q[gi]);
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    cnt_q       <= '0;
                    qual_q[gi]  <= 1'b0;
                end
                else if (clk_en)
                begin
                    if (act == qual_q[gi])
                        cnt_q <= '0;
                    else if (ms_tick)
                    begin
                        if (cnt_q + 16'd1 >= (qual_q[gi] ? off_ms_q : on_ms_q))
                        begin
                            qual_q[gi] <= act;
                            cnt_q      <= '0;
                        end
                        else
                            cnt_q <= cnt_q + 16'd1;
                    end
                end
            end
            // Event flag; new event wins over clear
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                    evt_q[gi] <= 1'b0;
                else if (clk_en)
                begin
                    if (evt_en_q[gi] && act != qual_q[gi] && ms_tick &&
                        cnt_q + 16'd1 >= (qual_q[gi] ? off_ms_q : on_ms_q))
                        evt_q[gi] <= 1'b1;
                    else if (cmd_pulse[`RIO_CMD_CLR_EVT])
                        evt_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Mapped input function outputs
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            func_active <= '0;
        else if (clk_en)
            for (int i = 0; i < NIN; i++)
                func_active[i] <= qual_q[i] && (fsel_q[5*i +: 5] != 5'd0);
    end

    // Relay channels
    genvar go;
    generate
        for (go = 0; go < NOUT; go++)
        begin : g_out
            logic [W-1:0] don_q, pw_q;
            logic         trig, any_lat, any_nl, any_pl, prev_q, on_q;
            rio_pkg::rio_role_e role;
            assign role = rio_pkg::rio_role_e'(role_q[2*go +: 2]);
            always_comb
            begin
                any_lat = 1'b0;
                any_nl  = 1'b0;
                any_pl  = 1'b0;
                for (int s = 0; s < NSIG; s++)
                begin
                    // Per-signal selection and mode
                    case (rmap_q[(go*NSIG+s)*2 +: 2])
                        rio_pkg::RIO_MODE_LATCH:   any_lat = any_lat | rlat_q[go*NSIG+s];
                        rio_pkg::RIO_MODE_NOLATCH: any_nl  = any_nl | int_sig[s];
                        rio_pkg::RIO_MODE_PULSE:   any_pl  = any_pl | int_sig[s];
                        default: ;
                    endcase
                end
                case (role)
                    rio_pkg::RIO_ROLE_TRIP:  trig = trip_sig | open_cmd | any_nl | any_lat | any_pl;
                    rio_pkg::RIO_ROLE_CLOSE: trig = close_cmd;
                    rio_pkg::RIO_ROLE_READY: trig = ready_sig;
                    default:                 trig = any_lat | any_nl | any_pl;
                endcase
            end
            // Latch memory per signal, held until relay reset
            for (genvar s = 0; s < NSIG; s++)
            begin : g_lat
                always_ff @(posedge clk or negedge nrst)
                begin
                    if (!nrst)
                        rlat_q[go*NSIG+s] <= 1'b0;
                    else if (clk_en)
                    begin
                        if (int_sig[s])
                            rlat_q[go*NSIG+s] <= 1'b1;
                        else if (cmd_pulse[`RIO_CMD_RST_RLY])
                            rlat_q[go*NSIG+s] <= 1'b0;
                    end
                end
            end
            // ON delay and pulse width timing
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    don_q <= '0; pw_q <= '0; prev_q <= 1'b0; on_q <= 1'b0;
                end
                else if (clk_en)
                begin
                    prev_q <= trig;
                    if (!trig)
                        don_q <= '0;
                    else if (ms_tick && don_q < oon_ms_q)
                        don_q <= don_q + 16'd1;
                    if (trig && don_q >= oon_ms_q && !on_q)
                    begin
                        on_q <= 1'b1;
                        pw_q <= '0;
                    end
                    else if (on_q)
                    begin
                        if (ms_tick && pw_q < pulse_ms_q)
                            pw_q <= pw_q + 16'd1;
                        if (pw_q >= pulse_ms_q && !(role == rio_pkg::RIO_ROLE_TRIP && trip_sig)
                            && !(any_nl || any_lat) && role != rio_pkg::RIO_ROLE_READY)
                            on_q <= 1'b0;
                        else if (!trig && role == rio_pkg::RIO_ROLE_READY)
                            on_q <= 1'b0;
                    end
                end
            end
            // Contact drive with idle polarity
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                    rly_q[go] <= 1'b0;
                else if (clk_en)
                    rly_q[go] <= on_q ^ (opol_q[go] && role != rio_pkg::RIO_ROLE_READY);
            end
        end
    endgenerate
    assign relay_out = rly_q;

    // LED channels
    genvar gl;
    generate
        for (gl = 0; gl < NLED; gl++)
        begin : g_led
            logic lit;
            always_comb
            begin
                lit = 1'b0;
                for (int s = 0; s < NSIG; s++)
                    case (lmap_q[(gl*NSIG+s)*2 +: 2])
                        rio_pkg::RIO_MODE_LATCH:   lit = lit | llat_q[gl*NSIG+s];
                        rio_pkg::RIO_MODE_NOLATCH: lit = lit | int_sig[s];
                        rio_pkg::RIO_MODE_PULSE:   lit = lit | (llat_q[gl*NSIG+s] & blink_ph_q);
                        default: ;
                    endcase
            end
            for (genvar s = 0; s < NSIG; s++)
            begin : g_lat
                always_ff @(posedge clk or negedge nrst)
                begin
                    if (!nrst)
                        llat_q[gl*NSIG+s] <= 1'b0;
                    else if (clk_en)
                    begin
                        if (int_sig[s])
                            llat_q[gl*NSIG+s] <= 1'b1;
                        else if (cmd_pulse[`RIO_CMD_RST_LED])
                            llat_q[gl*NSIG+s] <= 1'b0;
                    end
                end
            end
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                    led_q[gl] <= 1'b0;
                else if (clk_en)
                    led_q[gl] <= lit;
            end
        end
    endgenerate
    assign led_out = led_q;

    // Access level, passcode unlock and auto-lock
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lvl_q  <= rio_pkg::RIO_LVL_LOCKED;
            idle_q <= '0;
        end
        else if (clk_en)
        begin
            if (wr && wb_adr_i == `RIO_OFS_ACCESS)
            begin
                idle_q <= '0;
                if (wb_dat_i[15:0] == `RIO_PASS_L2)
                    lvl_q <= rio_pkg::RIO_LVL_TWO;
                else if (wb_dat_i[15:0] == `RIO_PASS_L1)
                    lvl_q <= rio_pkg::RIO_LVL_ONE;
                else
                    lvl_q <= rio_pkg::RIO_LVL_LOCKED;
            end
            else if (wr)
            begin
                // A lock command is itself a write, so it is handled here
                idle_q <= '0;
                if (cmd_pulse[`RIO_CMD_LOCK])
                    lvl_q <= rio_pkg::RIO_LVL_LOCKED;
            end
            else if (lvl_q != rio_pkg::RIO_LVL_LOCKED && ms_tick)
            begin
                if (idle_q + 32'd1 >= 32'(lock_min_q) * 32'(MIN_MS))
                begin
                    lvl_q  <= rio_pkg::RIO_LVL_LOCKED;
                    idle_q <= '0;
                end
                else
                    idle_q <= idle_q + 32'd1;
            end
        end
    end

    // Alarm-clear counter shows command activity
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            alarm_clr_cnt_q <= '0;
        else if (clk_en && (cmd_pulse[`RIO_CMD_CLR_ALARM] || cmd_pulse[`RIO_CMD_CLR_MAX]
                 || cmd_pulse[`RIO_CMD_CLR_REC] || cmd_pulse[`RIO_CMD_RST_LOCK]))
            alarm_clr_cnt_q <= alarm_clr_cnt_q + 8'd1;
    end

    // Locked flag output
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            locked <= 1'b1;
        else if (clk_en)
            locked <= (lvl_q == rio_pkg::RIO_LVL_LOCKED);
    end

    // Wishbone ack and read data
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else if (clk_en)
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            // Read data is captured when a request is taken and then stands
            if (wb_cyc_i && wb_stb_i && !wb_ack_o)
            begin
                case (wb_adr_i)
                    `RIO_OFS_ID:       wb_dat_o <= `RIO_ID_VALUE; // Arbitrary value
                    `RIO_OFS_IN_CFG0:  wb_dat_o <= {6'h00, evt_en_q, 6'h00, pol_q};
                    `RIO_OFS_IN_STATE: wb_dat_o <= {22'h00_0000, qual_q};
                    `RIO_OFS_EVT:      wb_dat_o <= {22'h00_0000, evt_q};
                    `RIO_OFS_TIMING:   wb_dat_o <= {off_ms_q, on_ms_q};
                    `RIO_OFS_OUT_CFG:  wb_dat_o <= {pulse_ms_q, oon_ms_q[7:0], 2'b00, opol_q};
                    `RIO_OFS_ROLE:     wb_dat_o <= {8'h00, lock_min_q, 4'h0, role_q};
                    `RIO_OFS_LED_MAP:  wb_dat_o <= lmap_q[31:0];
                    `RIO_OFS_STATUS:   wb_dat_o <= {6'h00, alarm_clr_cnt_q, 2'b00,
                                                   led_q, rly_q, lvl_q};
                    default:           wb_dat_o <= '0;
                endcase
            end
        end
    end

endmodule : rio_core
`default_nettype wire

// ### rio_defines.svh
`ifndef RIO_DEFINES_SVH
`define RIO_DEFINES_SVH

// Register byte offsets
`define RIO_OFS_ID        8'h00
`define RIO_OFS_IN_CFG0   8'h04
`define RIO_OFS_IN_STATE  8'h08
`define RIO_OFS_EVT       8'h0C
`define RIO_OFS_OUT_CFG   8'h10
`define RIO_OFS_RLY_MAP   8'h14
`define RIO_OFS_LED_MAP   8'h18
`define RIO_OFS_CMD       8'h1C
`define RIO_OFS_ACCESS    8'h20
`define RIO_OFS_STATUS    8'h24
`define RIO_OFS_TIMING    8'h28
`define RIO_OFS_ROLE      8'h2C
`define RIO_OFS_INSEL     8'h30

// Command bits in the command register
`define RIO_CMD_RST_LED    0
`define RIO_CMD_RST_RLY    1
`define RIO_CMD_RST_LOCK   2
`define RIO_CMD_CLR_ALARM  3
`define RIO_CMD_CLR_EVT    4
`define RIO_CMD_CLR_MAX    5
`define RIO_CMD_CLR_REC    6
`define RIO_CMD_LOCK       7

// Passcodes and access levels
`define RIO_PASS_L1       16'h03E8
`define RIO_PASS_L2       16'h07D0

// Timing
`define RIO_MS_NS         1000000
`define RIO_CLK_NS        25
`define RIO_MS_CYCLES     (`RIO_MS_NS / `RIO_CLK_NS)
`define RIO_MIN_MS        60000
`define RIO_LOCK_MIN_DEF  8'h0A
`define RIO_BLINK_MS      250
`define RIO_ID_VALUE      32'h5249_4F31

`endif

// ### rio_pkg.sv
package rio_pkg;
    typedef enum logic [1:0] {
        RIO_MODE_OFF     = 2'b00,
        RIO_MODE_LATCH   = 2'b01,
        RIO_MODE_NOLATCH = 2'b10,
        RIO_MODE_PULSE   = 2'b11
    } rio_mode_e;

    typedef enum logic [1:0] {
        RIO_ROLE_GEN   = 2'b00,
        RIO_ROLE_TRIP  = 2'b01,
        RIO_ROLE_CLOSE = 2'b10,
        RIO_ROLE_READY = 2'b11
    } rio_role_e;

    typedef enum logic [1:0] {
        RIO_LVL_LOCKED = 2'b00,
        RIO_LVL_ONE    = 2'b01,
        RIO_LVL_TWO    = 2'b10
    } rio_lvl_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } rio_wb_req_s;
endpackage : rio_pkg

// ### rio_checker.sv
`timescale 1ns/100ps
`default_nettype none
module rio_checker #(
    parameter int NIN  = 10,
    parameter int NOUT = 6
) (
    // Clock and reset
    input wire logic            clk,
    input wire logic            nrst,
    // Register bus
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic            wb_we_i,
    input wire logic [7:0]      wb_adr_i,
    input wire logic [31:0]     wb_dat_i,
    input wire logic [31:0]     wb_dat_o,
    input wire logic            wb_ack_o,
    // Field side
    input wire logic [NIN-1:0]  field_input,
    input wire logic [NIN-1:0]  func_active,
    input wire logic [NOUT-1:0] relay_out,
    input wire logic            locked
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Write to the access register at its accepting edge
    logic acc_wr;
    assign acc_wr = wb_ack_o && wb_we_i && wb_adr_i == 8'h20;
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_hold: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
        else $error("read data moved while idle");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h34
        |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
    a_reset_state: assert property ($rose(nrst) |-> locked && relay_out == '0)
        else $error("bad state after reset");
    a_lock_cmd: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h1C
        && wb_dat_i[7] |-> ##[1:2] locked) else $error("lock command ignored");
    a_pass_two: assert property (acc_wr && wb_dat_i == 32'h0000_07D0
        |-> ##[1:2] !locked) else $error("level two passcode refused");
    a_bad_pass: assert property (acc_wr && wb_dat_i != 32'h0000_07D0
        && wb_dat_i != 32'h0000_03E8 |-> ##[1:2] locked) else $error("bad passcode unlocked");
    a_qualify: assert property ($changed(func_active)
        |-> $past(field_input, 3) == $past(field_input, 8)) else $error("input unqualified");
endmodule : rio_checker
bind rio_core rio_checker #(.NIN(NIN), .NOUT(NOUT)) u_chk (.clk(clk), .nrst(nrst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .field_input(field_input), .func_active(func_active), .relay_out(relay_out),
    .locked(locked));
`default_nettype wire

// ### rio_field_model.sv
`timescale 1ns/100ps
`default_nettype none
module rio_field_model #(
    parameter int NIN = 10
) (
    // Clock and wanted contact states
    input wire logic           clk,
    input wire logic [NIN-1:0] want,
    // Terminal levels
    output logic     [NIN-1:0] field_input
);
    logic [NIN-1:0] last_q;
    logic [NIN-1:0] old_q;
    int             bounce_q;
    initial
    begin
        field_input = '0;
        last_q = '0;
        old_q = '0;
        bounce_q = 0;
    end
    // A moved contact chatters for six cycles before it settles
    always @(posedge clk)
    begin
        if (want != last_q)
        begin
            old_q <= last_q;
            last_q <= want;
            bounce_q <= 6;
        end
        else if (bounce_q > 0)
            bounce_q <= bounce_q - 1;
        field_input <= (bounce_q > 0 && !bounce_q[0]) ? old_q : last_q;
    end
endmodule : rio_field_model
`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk, nrst, cyc, stb, we, trip, opn, wb_ack_o, locked, cls, rdy;
    logic [7:0]  adr, led_out;
    logic [4:0]  isig;
    logic [31:0] dat, q, wb_dat_o;
    logic [9:0]  want, fin, func_active;
    logic [5:0]  relay_out;
    int          err_total, checks;
    // Device under test with short millisecond and minute counts
    rio_core #(.MS_CYCLES(4), .MIN_MS(2)) i_dut (.clk(clk), .nrst(nrst), .clk_en(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hF), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .field_input(fin),
        .int_sig(isig), .trip_sig(trip), .open_cmd(opn), .close_cmd(cls),
        .ready_sig(rdy), .relay_out(relay_out), .led_out(led_out), .func_active(func_active),
        .locked(locked));
    rio_field_model #(.NIN(10)) i_field (.clk(clk), .want(want), .field_input(fin));
    // Clock
    always #12.5 clk = ~clk;
    task automatic final_report();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // One classic cycle, entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        if (n >= 50)
            err_total++;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask : rdchk
    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        final_report();
    end
    // Main sequence
    initial
    begin
        clk = 0; nrst = 0; cyc = 0; stb = 0; we = 0; adr = '0; dat = '0; cls = 0; rdy = 0;
        trip = 0; opn = 0; want = '0; q = '0; err_total = 0; checks = 0; isig = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(32'(locked), 32'h0000_0001);
        wr(8'hFC, 32'h0000_00FF);
        rdchk(8'hFC, 32'h0000_0000);
        wr(8'h28, 32'h0003_0003);
        rdchk(8'h28, 32'h0014_0014);
        wr(8'h20, 32'h0000_03E8);
        chk(32'(locked), 32'h0000_0000);
        wr(8'h28, 32'h0003_0003);
        rdchk(8'h28, 32'h0014_0014);
        wr(8'h20, 32'h0000_1234);
        chk(32'(locked), 32'h0000_0001);
        wr(8'h20, 32'h0000_07D0);
        wr(8'h28, 32'h0003_0003);
        rdchk(8'h28, 32'h0003_0003);
        wr(8'h04, 32'h0001_03FD);
        wr(8'h30, 32'h0000_0001);
        wr(8'h10, 32'h0004_0200);
        wr(8'h2C, 32'h003C_0001);
        repeat (40) @(posedge clk);
        rdchk(8'h08, 32'h0000_0002);
        want <= 10'h001;
        repeat (6) @(posedge clk);
        rdchk(8'h08, 32'h0000_0002);
        repeat (60) @(posedge clk);
        rdchk(8'h08, 32'h0000_0003);
        chk(32'(func_active), 32'h0000_0001);
        rdchk(8'h0C, 32'h0000_0001);
        wr(8'h1C, 32'h0000_0010);
        rdchk(8'h0C, 32'h0000_0000);
        wr(8'h1C, 32'h0000_0080);
        chk(32'(locked), 32'h0000_0001);
        want <= 10'h000;
        repeat (60) @(posedge clk);
        wr(8'h1C, 32'h0000_0010);
        rdchk(8'h08, 32'h0000_0002);
        rdchk(8'h0C, 32'h0000_0001);
        trip <= 1'b1;
        repeat (40) @(posedge clk);
        chk(32'(relay_out[0]), 32'h0000_0001);
        trip <= 1'b0;
        repeat (30) @(posedge clk);
        chk(32'(relay_out[0]), 32'h0000_0000);
        opn <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(relay_out[0]), 32'h0000_0000);
        repeat (10) @(posedge clk);
        chk(32'(relay_out[0]), 32'h0000_0001);
        opn <= 1'b0;
        repeat (30) @(posedge clk);
        chk(32'(relay_out[0]), 32'h0000_0000);
        wr(8'h20, 32'h0000_07D0);
        wr(8'h18, 32'h0000_0001);
        isig <= 5'h01;
        repeat (2) @(posedge clk);
        isig <= 5'h00;
        repeat (3) @(posedge clk);
        chk(32'(led_out[0]), 32'h0000_0001);
        wr(8'h1C, 32'h0000_0001);
        chk(32'(led_out[0]), 32'h0000_0000);
        wr(8'h2C, 32'h0001_0001);
        chk(32'(locked), 32'h0000_0000);
        repeat (40) @(posedge clk);
        chk(32'(locked), 32'h0000_0001);
        final_report();
    end
endmodule : testbench
`default_nettype wire
